// ### rtl/smm_pkg.sv
// Purpose: Shared constants and carriers of the motion state manager
// Assumes: 32-bit APB, 11-bit positions, one 200 MHz clock
// Notes:   Offsets are byte addresses of aligned words
package smm_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] SMM_CTRL_OFS    = 8'h00;
	localparam logic [7:0] SMM_CMD_OFS     = 8'h04;
	localparam logic [7:0] SMM_POS_OFS     = 8'h08;
	localparam logic [7:0] SMM_PARAM_OFS   = 8'h0C;
	localparam logic [7:0] SMM_STATUS_OFS  = 8'h10;
	localparam logic [7:0] SMM_PHYS_OFS    = 8'h14;
	localparam logic [7:0] SMM_COIL_OFS    = 8'h18;
	localparam logic [7:0] SMM_RDPAR_OFS   = 8'h1C;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int SMM_POS_W       = 11;
	localparam int SMM_VEL_W       = 4;
	localparam int SMM_CUR_W       = 4;
	localparam int SMM_TAG_LSB     = 0;
	localparam int SMM_SEC_LSB     = 16;
	localparam int SMM_VMAX_LSB    = 0;
	localparam int SMM_VMIN_LSB    = 4;
	localparam int SMM_ACC_LSB     = 8;
	localparam int SMM_IRUN_LSB    = 12;
	localparam int SMM_IHOLD_LSB   = 16;
	localparam int SMM_SHAPE_BIT   = 20;
	localparam int SMM_BOOSTD_BIT  = 21;
	localparam int SMM_STAB_LSB    = 22;
	localparam int SMM_DORM_BIT    = 24;

	// -----------------------------------------------------------------
	// Command codes written to the command register
	// -----------------------------------------------------------------
	localparam logic [3:0] SMM_CMD_SETPOS   = 4'h1;
	localparam logic [3:0] SMM_CMD_SHORTPOS = 4'h2;
	localparam logic [3:0] SMM_CMD_SECURE   = 4'h3;
	localparam logic [3:0] SMM_CMD_TWOPH    = 4'h4;
	localparam logic [3:0] SMM_CMD_SOFT     = 4'h5;
	localparam logic [3:0] SMM_CMD_HARD     = 4'h6;
	localparam logic [3:0] SMM_CMD_SLEEP    = 4'h7;
	localparam logic [3:0] SMM_CMD_STATUS   = 4'h8;
	localparam logic [3:0] SMM_CMD_FSTATUS  = 4'h9;
	localparam logic [3:0] SMM_CMD_PARAM    = 4'hA;
	localparam logic [3:0] SMM_CMD_DYNID    = 4'hB;
	localparam logic [3:0] SMM_CMD_TIMEOUT  = 4'hC;

	// -----------------------------------------------------------------
	// Reset values and timing
	// -----------------------------------------------------------------
	localparam logic [SMM_POS_W-1:0] SMM_SEC_DIS = 11'h400;
	localparam logic [31:0] SMM_PARAM_RST = 32'h0120_0000;
	localparam int SMM_CLK_MHZ     = 200;
	localparam int SMM_STAB_US0    = 1;
	localparam int SMM_STAB_CYC0   = SMM_STAB_US0 * SMM_CLK_MHZ;
	localparam int SMM_CNT_W       = 16;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		SMM_STANDBY, SMM_STOPPED, SMM_TRAVEL, SMM_TWOPH,
		SMM_DECEL, SMM_HARDSTOP, SMM_SHUTDOWN, SMM_SLEEP
	} smm_state_t;

	typedef struct packed {
		logic [SMM_VEL_W-1:0] vmax;
		logic [SMM_VEL_W-1:0] vmin;
		logic [SMM_VEL_W-1:0] acc;
		logic                 shape;
	} smm_motion_t;

	typedef struct packed {
		logic tsd;
		logic uv;
		logic eldef;
		logic warm;
		logic cold;
	} smm_phys_t;

	typedef struct packed {
		logic                 psel;
		logic                 penable;
		logic                 pwrite;
		logic [7:0]           paddr;
		logic [31:0]          pwdata;
	} smm_apb_req_t;

endpackage

// ### rtl/smm_stab_timer.sv
// Purpose: Coil stabilization timer with four selectable lengths
// Assumes: Start is a one-cycle pulse on the block clock
// Notes:   Done pulses once when the selected count has elapsed
module smm_stab_timer
	import smm_pkg::*;
#(
	parameter int BASE_CYC = SMM_STAB_CYC0
) (
	input  wire logic       clk,   // Block clock
	input  wire logic       rst_n, // Sync reset, low
	input  wire logic       ce,    // Clock enable
	input  wire logic       start, // Begin a stabilization wait
	input  wire logic [1:0] sel,   // One of four lengths
	output logic            busy,  // Waiting
	output logic            done   // End pulse
);

	// Elaboration check: longest length must fit the counter
	if (BASE_CYC < 1 || BASE_CYC * 8 >= (1 << SMM_CNT_W)) begin
		$error("smm_stab_timer: BASE_CYC out of range");
	end

	typedef struct packed {
		logic [SMM_CNT_W-1:0] cnt;
		logic                 busy;
		logic                 done;
	} smm_tmr_t;

	smm_tmr_t st_reg;
	smm_tmr_t st_next;

	// -----------------------------------------------------------------
	// Length = BASE * 1,2,4,8 chosen by sel
	// -----------------------------------------------------------------
	function automatic logic [SMM_CNT_W-1:0] stab_len(input logic [1:0] s);
		stab_len = SMM_CNT_W'(BASE_CYC) << s;
	endfunction

	// Count down while busy
	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		if (start) begin
			st_next.busy = 1'b1;
			st_next.cnt  = stab_len(sel) - SMM_CNT_W'(1);
		end else if (st_reg.busy) begin
			if (st_reg.cnt == '0) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt - SMM_CNT_W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end

	assign busy = st_reg.busy;
	assign done = st_reg.done;

endmodule

// ### rtl/smm_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Inputs are slow levels from outside the clock domain
// Notes:   First stage is read only by the second
module smm_sync #(
	parameter int W = 5
) (
	input  wire logic         clk,   // Block clock
	input  wire logic         rst_n, // Sync reset, low
	input  wire logic         ce,    // Clock enable
	input  wire logic [W-1:0] d,     // Asynchronous levels
	output logic      [W-1:0] q      // Synchronised levels
);

	// Elaboration check of the width
	if (W < 1) begin
		$error("smm_sync: W must be positive");
	end

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;

	// Two flip-flop stages
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else if (ce) begin
			s1_reg <= d;
			s2_reg <= s1_reg;
		end
	end

	assign q = s2_reg;

endmodule

// ### rtl/smm_core.sv
// Purpose: Motion state manager of a stepper positioner, APB slave
// Assumes: Position counter and drive stage are outside this block
// Notes:   Commands arrive as writes to the command register
//
// Contract
// (R01) Leaving sleep acts as full reset
// (R02) Standby entered right after power-on reset
// (R03) Two-phase motion uses own copied parameters
// (R04) Shape forced to one in second phase
// (R05) Full status reports normal velocity values
// (R06) Sleep request set by timeout/command, cleared next
// (R07) Shutdown held until thermal and stop flags clear
// (R08) Faults clear after status read, conditions normal
// (R09) Master avoids acc/vmin change during travel
// (R10) Two-phase parameter writes apply at next set-position
// (R11) Travel to sleep passes decel then stopped
// (R12) Stopped with request: sleep or secure travel
// (R13) Secure enable high unless most negative code
// (R14) Stop-origin set leaving stops, cleared in stopped
// (R15) Identifier command decoded except in sleep
// (R16) Position difference starts travel, lowest priority
// (R17) Step loss keeps positioning; cleared by status
// (R18) Dormancy allow zero forbids stopped to sleep
// (R19) Boost-disable zero raises currents when cold
// (R20) Warm temperature sets boost-disable back
// (R21) Motion start steps hold to run current
// (R22) Stop holds currents, then hold level, then ready
// (R23) Stabilization time has four bus settings
//
// Chosen here: the placing of the registers and the APB slave port.
module smm_core
	import smm_pkg::*;
#(
	parameter int STAB_BASE = SMM_STAB_CYC0
) (
	input  wire logic                 CLOCK,       // Block clock
	input  wire logic                 RSTN,        // Sync reset, low
	input  wire logic                 CE,          // Clock enable
	input  wire logic                 PSEL,        // APB select
	input  wire logic                 PENABLE,     // APB access phase
	input  wire logic                 PWRITE,      // APB write
	input  wire logic [7:0]           PADDR,       // APB byte address
	input  wire logic [31:0]          PWDATA,      // APB write data
	output logic      [31:0]          PRDATA,      // APB read data
	output logic                      PREADY,      // APB ready
	output logic                      PSLVERR,     // APB error
	input  wire logic [SMM_POS_W-1:0] ACT_POS,     // Actual position
	input  wire logic                 MOTION_DONE, // Motion finished
	input  wire logic                 STEP_LOSS_IN,// Step loss event
	input  wire smm_phys_t            PHYS,        // Pin conditions
	output logic      [SMM_POS_W-1:0] TARGET_POS,  // Target position
	output smm_motion_t               MOTION,      // Active motion set
	output logic      [SMM_CUR_W-1:0] COIL_LEVEL,  // Current set point
	output logic                      COIL_RUN,    // Run current on
	output logic                      COIL_FREEZE, // Hold DC level
	output logic                      BOOST_ON,    // Boost active
	output logic                      HBRIDGE_OFF, // Bridges Hi-Z
	output logic                      SLEEP_ACT,   // Sleep entered
	output logic                      DYNID_STB    // Id assign strobe
);

	// Elaboration check of the base count
	if (STAB_BASE < 1) begin
		$error("smm_core: STAB_BASE must be positive");
	end

	// -----------------------------------------------------------------
	// State of the block
	// -----------------------------------------------------------------
	typedef struct packed {
		smm_state_t           state;
		logic [SMM_POS_W-1:0] tag;
		logic [SMM_POS_W-1:0] sec;
		logic [31:0]          param;   // Normal RAM parameters
		logic [31:0]          pend;    // Writes held during two-phase
		logic                 pend_v;
		smm_motion_t          tp;      // Two-phase working set
		logic                 phase2;
		logic [SMM_POS_W-1:0] tp_tag2;
		logic                 sleep_req;
		logic                 stop_org;
		logic                 hs;
		logic                 tsd;
		logic                 uv;
		logic                 eldef;
		logic                 steploss;
		logic                 stab_wait;
		logic                 dynid;
		logic [31:0]          rdata;
	} smm_st_t;

	smm_st_t   r_reg;
	smm_st_t   r_next;
	smm_phys_t phys_s;
	logic      stab_busy;
	logic      stab_done;
	logic      stab_start;

	// Pin conditions pass two flip-flops
	smm_sync #(.W($bits(smm_phys_t))) u_sync (
		.clk   (CLOCK),
		.rst_n (RSTN),
		.ce    (CE),
		.d     (PHYS),
		.q     (phys_s)
	);

	// Stabilization timer with four lengths
	smm_stab_timer #(.BASE_CYC(STAB_BASE)) u_stab ( // R23
		.clk   (CLOCK),
		.rst_n (RSTN),
		.ce    (CE),
		.start (stab_start),
		.sel   (r_reg.param[SMM_STAB_LSB+:2]),
		.busy  (stab_busy),
		.done  (stab_done)
	);

	// -----------------------------------------------------------------
	// Decode helpers
	// -----------------------------------------------------------------
	function automatic smm_motion_t norm_set(input logic [31:0] p);
		norm_set.vmax  = p[SMM_VMAX_LSB+:SMM_VEL_W];
		norm_set.vmin  = p[SMM_VMIN_LSB+:SMM_VEL_W];
		norm_set.acc   = p[SMM_ACC_LSB+:SMM_VEL_W];
		norm_set.shape = p[SMM_SHAPE_BIT];
	endfunction

	function automatic logic is_status(input logic [3:0] c);
		is_status = (c == SMM_CMD_STATUS) || (c == SMM_CMD_FSTATUS);
	endfunction

	logic       apb_wr;
	logic       apb_rd;
	logic [3:0] cmd;
	logic       cmd_v;
	logic       sec_en;
	logic       phys_ok;

	assign apb_wr  = PSEL && PENABLE && PWRITE;
	assign apb_rd  = PSEL && PENABLE && !PWRITE;
	assign cmd     = PWDATA[3:0];
	assign cmd_v   = apb_wr && (PADDR == SMM_CMD_OFS) && CE;
	assign sec_en  = (r_reg.sec != SMM_SEC_DIS); // R13
	assign phys_ok = !phys_s.tsd && !phys_s.uv && !phys_s.eldef;

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	always_comb begin
		r_next       = r_reg;
		r_next.dynid = 1'b0;
		stab_start   = 1'b0;
		// Physical faults latch
		if (phys_s.tsd)   r_next.tsd   = 1'b1;
		if (phys_s.uv)    r_next.uv    = 1'b1;
		if (phys_s.eldef) r_next.eldef = 1'b1;
		if (phys_s.eldef) r_next.hs    = 1'b1;
		// Warm die drops boost
		if (phys_s.warm)
			r_next.param[SMM_BOOSTD_BIT] = 1'b1; // R20
		// Register writes
		if (apb_wr && PADDR == SMM_POS_OFS) begin
			r_next.sec = PWDATA[SMM_SEC_LSB+:SMM_POS_W];
		end
		if (apb_wr && PADDR == SMM_CTRL_OFS) begin
			r_next.param[SMM_STAB_LSB+:2] = PWDATA[SMM_STAB_LSB+:2];
			r_next.param[SMM_DORM_BIT]    = PWDATA[SMM_DORM_BIT];
		end
		// Bus commands, any one but sleep or timeout cancels a pending sleep request
		if (cmd_v && r_reg.state != SMM_SLEEP) begin
			r_next.sleep_req = 1'b0; // R06
			case (cmd)
				SMM_CMD_SLEEP, SMM_CMD_TIMEOUT:
					r_next.sleep_req = 1'b1; // R06
				SMM_CMD_PARAM:
					if (r_reg.state == SMM_TWOPH) begin
						r_next.pend   = PWDATA; // R10
						r_next.pend_v = 1'b1;
					end else begin
						r_next.param = PWDATA;
					end
				SMM_CMD_SETPOS, SMM_CMD_SHORTPOS: begin
					// Step loss does not block positioning
					r_next.tag = PWDATA[16+:SMM_POS_W]; // R17
					if (r_reg.pend_v) begin
						r_next.param  = r_reg.pend; // R10
						r_next.pend_v = 1'b0;
					end
				end
				SMM_CMD_SECURE:
					if (sec_en) r_next.tag = r_reg.sec; // R17
				SMM_CMD_TWOPH:
					if (r_reg.state == SMM_STOPPED && !r_reg.stab_wait) begin
						r_next.state   = SMM_TWOPH;
						r_next.tp      = norm_set(r_reg.param); // R03
						r_next.tp.vmax = PWDATA[4+:SMM_VEL_W]; // R03
						r_next.tag     = PWDATA[8+:SMM_POS_W];
						r_next.tp_tag2 = PWDATA[20+:SMM_POS_W];
						r_next.phase2  = 1'b0;
					end
				SMM_CMD_SOFT:
					if (r_reg.state == SMM_TRAVEL)
						r_next.state = SMM_DECEL;
				SMM_CMD_HARD:
					if (r_reg.state inside {SMM_TRAVEL, SMM_TWOPH,
						SMM_DECEL}) begin
						r_next.state    = SMM_HARDSTOP;
						r_next.hs       = 1'b1;
						r_next.steploss = 1'b1;
					end
				SMM_CMD_STATUS, SMM_CMD_FSTATUS: begin
					if (phys_ok) begin
						r_next.tsd   = 1'b0; // R08
						r_next.uv    = 1'b0; // R08
						r_next.eldef = 1'b0; // R08
						r_next.hs    = 1'b0; // R08
					end
					r_next.steploss = 1'b0; // R17
				end
				SMM_CMD_DYNID:
					r_next.dynid = 1'b1; // R15
				default: ;
			endcase
		end
		// Step loss set wins over a status clear
		if (STEP_LOSS_IN) r_next.steploss = 1'b1;
		// Status read snapshot, normal velocities only
		if (cmd_v && is_status(cmd))
			r_next.rdata = {20'h0, r_reg.param[SMM_ACC_LSB+:4],
				r_reg.param[SMM_VMIN_LSB+:4],
				r_reg.param[SMM_VMAX_LSB+:4]}; // R05
		// Stabilization after a finished travel, two-phase move or stop
		if (stab_done) r_next.stab_wait = 1'b0; // R22
		// Priority encoder
		case (r_reg.state)
			SMM_STANDBY:
				r_next.state = SMM_STOPPED; // R02
			SMM_STOPPED: begin
				r_next.stop_org = 1'b0; // R14
				if (r_reg.tsd || r_reg.eldef)
					r_next.state = SMM_SHUTDOWN;
				else if (r_reg.sleep_req && !r_reg.stab_wait) begin
					if (!sec_en || ACT_POS == r_reg.sec || r_reg.stop_org) begin
						if (r_reg.param[SMM_DORM_BIT]) // R18
							r_next.state = SMM_SLEEP; // R12
					end else begin
						r_next.tag   = r_reg.sec; // R12
						r_next.state = SMM_TRAVEL;
					end
				end else if (ACT_POS != r_reg.tag && !r_reg.stab_wait)
					r_next.state = SMM_TRAVEL; // R16
			end
			SMM_TRAVEL:
				if (r_reg.tsd || r_reg.sleep_req)
					r_next.state = SMM_DECEL; // R11
				else if (MOTION_DONE) begin
					r_next.state     = SMM_STOPPED;
					r_next.stab_wait = 1'b1;
					stab_start       = 1'b1; // R22
				end
			SMM_TWOPH:
				if (r_reg.tsd)
					r_next.state = SMM_DECEL;
				else if (MOTION_DONE && !r_reg.phase2) begin
					r_next.phase2 = 1'b1;
					r_next.tag    = r_reg.tp_tag2;
				end else if (MOTION_DONE) begin
					r_next.phase2    = 1'b0;
					r_next.state     = SMM_STOPPED;
					r_next.stab_wait = 1'b1;
					stab_start       = 1'b1; // R22
				end
			SMM_DECEL, SMM_HARDSTOP:
				if (MOTION_DONE) begin
					r_next.state     = SMM_STOPPED;
					r_next.tag       = ACT_POS;
					r_next.stop_org  = 1'b1; // R14
					r_next.phase2    = 1'b0;
					r_next.stab_wait = 1'b1;
					stab_start       = 1'b1; // R22
				end
			SMM_SHUTDOWN: begin
				r_next.tag = ACT_POS;
				if (!r_reg.tsd && !r_reg.hs) // R07
					r_next.state = SMM_STOPPED;
				else if (cmd_v && cmd == SMM_CMD_TIMEOUT)
					r_next.state = SMM_SLEEP;
			end
			SMM_SLEEP:
				// Wake acts as power-on reset
				if (cmd_v) r_next = '0; // R01
			default:
				r_next.state = SMM_STANDBY;
		endcase
		if (r_reg.state == SMM_SLEEP && cmd_v) begin
			r_next.param = SMM_PARAM_RST; // R01
			r_next.sec   = SMM_SEC_DIS;
		end
	end

	// State register
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			r_reg       <= '0; // R02
			r_reg.param <= SMM_PARAM_RST;
			r_reg.sec   <= SMM_SEC_DIS;
		end else if (CE) begin
			r_reg <= r_next;
		end
	end

	// -----------------------------------------------------------------
	// Motion and coil outputs
	// -----------------------------------------------------------------
	smm_motion_t act_set;
	logic        cold_boost;

	always_comb begin
		act_set = (r_reg.state == SMM_TWOPH) ? r_reg.tp
			: norm_set(r_reg.param);
		if (r_reg.state == SMM_TWOPH && r_reg.phase2)
			act_set.shape = 1'b1; // R04
	end

	assign cold_boost = !r_reg.param[SMM_BOOSTD_BIT] && phys_s.cold; // R19
	assign MOTION      = act_set;
	assign TARGET_POS  = r_reg.tag;
	assign COIL_RUN    = r_reg.state inside {SMM_TRAVEL, SMM_TWOPH,
		SMM_DECEL, SMM_HARDSTOP}; // R21
	assign COIL_LEVEL  = COIL_RUN ? r_reg.param[SMM_IRUN_LSB+:SMM_CUR_W]
		: r_reg.param[SMM_IHOLD_LSB+:SMM_CUR_W]; // R21
	assign COIL_FREEZE = stab_busy; // R22
	assign BOOST_ON    = cold_boost; // R19
	assign HBRIDGE_OFF = (r_reg.state == SMM_SHUTDOWN);
	assign SLEEP_ACT   = (r_reg.state == SMM_SLEEP);
	assign DYNID_STB   = r_reg.dynid;

	// -----------------------------------------------------------------
	// APB read side
	// -----------------------------------------------------------------
	always_comb begin
		case (PADDR)
			SMM_CTRL_OFS:   PRDATA = {7'h0, r_reg.param[SMM_DORM_BIT],
				r_reg.param[SMM_STAB_LSB+:2], 22'h0};
			SMM_POS_OFS:    PRDATA = {5'h0, r_reg.sec, 5'h0, r_reg.tag};
			SMM_PARAM_OFS:  PRDATA = r_reg.param;
			SMM_STATUS_OFS: PRDATA = {16'h0, 4'(r_reg.state),
				r_reg.pend_v, r_reg.phase2, r_reg.stop_org, r_reg.sleep_req,
				sec_en, r_reg.steploss, r_reg.hs, r_reg.eldef,
				r_reg.uv, r_reg.tsd, r_reg.stab_wait, 1'b0};
			SMM_PHYS_OFS:   PRDATA = {27'h0, phys_s};
			SMM_COIL_OFS:   PRDATA = {25'h0, BOOST_ON, COIL_FREEZE,
				COIL_RUN, COIL_LEVEL};
			SMM_RDPAR_OFS:  PRDATA = r_reg.rdata;
			SMM_CMD_OFS:    PRDATA = 32'h0000_0000;
			default:        PRDATA = 32'h0000_0000;
		endcase
	end

	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !(PADDR inside {SMM_CTRL_OFS,
		SMM_CMD_OFS, SMM_POS_OFS, SMM_PARAM_OFS, SMM_STATUS_OFS,
		SMM_PHYS_OFS, SMM_COIL_OFS, SMM_RDPAR_OFS});

endmodule

// ### test/smm_core_asserts.sv
// Purpose: Port assertions of the motion state manager
// Assumes: Bound to smm_core, one clock, sync reset
// Notes:   Stabilization base kept small by the bench
module smm_core_asserts (
	input wire logic                  CLOCK,       // Clock
	input wire logic                  RSTN,        // Reset, low
	input wire logic                  CE,          // Enable
	input wire logic                  PSEL,        // Select
	input wire logic                  PENABLE,     // Access
	input wire logic                  PWRITE,      // Write
	input wire logic [7:0]            PADDR,       // Address
	input wire logic [31:0]           PWDATA,      // Write data
	input wire logic                  PREADY,      // Ready
	input wire logic                  PSLVERR,     // Error
	input wire smm_pkg::smm_phys_t    PHYS,        // Conditions
	input wire logic [10:0]           TARGET_POS,  // Target
	input wire smm_pkg::smm_motion_t  MOTION,      // Motion set
	input wire logic                  COIL_RUN,    // Run current
	input wire logic                  COIL_FREEZE, // DC hold
	input wire logic                  BOOST_ON,    // Boost
	input wire logic                  SLEEP_ACT,   // Asleep
	input wire logic                  DYNID_STB    // Id strobe
);
	import smm_pkg::*;
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	AST_READY: assert property (PSEL && PENABLE |-> PREADY)
		else $error("access not ready");
	AST_UNMAP: assert property (PSEL && PENABLE && PADDR > 8'h1C
		|-> PSLVERR) else $error("unmapped without error");
	AST_MAPPED: assert property (PSEL && PENABLE && PADDR <= 8'h1C
		&& PADDR[1:0] == 2'h0 |-> !PSLVERR) else $error("bad error");
	AST_DYNID: assert property (PSEL && PENABLE && PWRITE && CE
		&& PADDR == SMM_CMD_OFS && PWDATA[3:0] == SMM_CMD_DYNID
		&& !SLEEP_ACT |-> ##[1:2] DYNID_STB) else $error("no id strobe");
	AST_DYNKEEP: assert property ($rose(DYNID_STB) |->
		$stable(TARGET_POS) && $stable(SLEEP_ACT)) else $error("id moved");
	AST_START: assert property ($rose(COIL_RUN) |-> !COIL_FREEZE)
		else $error("run while frozen");
	AST_FREEZE: assert property ($rose(COIL_FREEZE)
		|-> ##[1:300] !COIL_FREEZE) else $error("freeze too long");
	AST_HOLDRUN: assert property ($fell(COIL_FREEZE) |-> !COIL_RUN)
		else $error("run after freeze");
	AST_WARM: assert property (PHYS.warm [*5] |-> !BOOST_ON)
		else $error("boost while warm");
	AST_RESET: assert property ($rose(RSTN) |-> !SLEEP_ACT
		&& !COIL_RUN && MOTION.shape == SMM_PARAM_RST[SMM_SHAPE_BIT])
		else $error("bad reset state");
endmodule
bind smm_core smm_core_asserts u_ast (.*);

// ### test/smm_apb_master.sv
// Purpose: Bus master model issuing commands to the block
// Assumes: Slave answers in its own time
// Notes:   Released address and data are inverted
module smm_apb_master (
	input  wire logic            clk,    // Clock
	output smm_pkg::smm_apb_req_t req,   // Request
	input  wire logic            pready  // Ready
);
	timeunit 1ns;
	timeprecision 100ps;
	import smm_pkg::*;
	initial req = '0;
	// One transfer: setup, access until ready, release
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		req.paddr <= ~a;
		req.pwdata <= ~d;
	endtask
endmodule

// ### test/tb_smm_core.sv
// Purpose: Self-checking bench of the motion state manager
// Assumes: Reads checked through a queue of notes
// Notes:   Small stabilization base keeps runs short
module tb_smm_core;
	timeunit 1ns;
	timeprecision 100ps;
	import smm_pkg::*;
	localparam int STB = 4;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITF(c) for (k = 0; !(c) && k < 400; k++) @(posedge clk);
	logic clk, rst_n, ce, done, prdy, perr, run, frz, bst, hoff, slp, dyn;
	logic [10:0] act, tgt, tag, t2;
	logic [31:0] prd, p;
	logic [3:0] lvl;
	logic [64:0] expq[$];
	logic [64:0] e;
	smm_apb_req_t req;
	smm_phys_t phys;
	smm_motion_t mot;
	int n_errors, cmp_count, k, n, len[4];
	// ------------------------------------------------------------
	// Design, bus master and clock
	// ------------------------------------------------------------
	smm_core #(.STAB_BASE(STB)) uut (.CLOCK(clk), .RSTN(rst_n), .CE(ce),
		.PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite),
		.PADDR(req.paddr), .PWDATA(req.pwdata), .PRDATA(prd),
		.PREADY(prdy), .PSLVERR(perr), .ACT_POS(act), .MOTION_DONE(done),
		.STEP_LOSS_IN(1'b0), .PHYS(phys), .TARGET_POS(tgt), .MOTION(mot),
		.COIL_LEVEL(lvl), .COIL_RUN(run), .COIL_FREEZE(frz),
		.BOOST_ON(bst), .HBRIDGE_OFF(hoff), .SLEEP_ACT(slp),
		.DYNID_STB(dyn));
	smm_apb_master m (.clk(clk), .req(req), .pready(prdy));
	always #2.5 clk = ~clk;
	// Read monitor takes the oldest note
	always @(posedge clk)
		if (req.psel && req.penable && prdy && !req.pwrite) begin
			e = expq.pop_front();
			`CHK(prd & e[63:32], e[31:0])
			`CHK(perr, e[64])
		end
	task automatic rd(input logic [7:0] a, input logic [31:0] mk,
		input logic [31:0] x, input logic er);
		expq.push_back({er, mk, x});
		m.xfer(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		m.xfer(1'b1, a, d);
	endtask
	task automatic close_out;
		n_errors += expq.size();
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		clk = 0; rst_n = 0; ce = 1; done = 0; act = '0; phys = '0;
		n_errors = 0; cmp_count = 0;
		void'($urandom(32'hD280));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(SMM_PARAM_OFS, 32'hFFFFFFFF, SMM_PARAM_RST, 1'b0);
		rd(SMM_POS_OFS, 32'h07FF0000, {5'h0, SMM_SEC_DIS, 16'h0}, 1'b0);
		rd(8'h20, 32'h0, 32'h0, 1'b1);
		p = ($urandom & 32'h001FFFF0) | 32'h00200000 | 32'(SMM_CMD_PARAM);
		wr(SMM_CMD_OFS, p);
		rd(SMM_PARAM_OFS, 32'h003FFFFF, p, 1'b0);
		// Boost on when cold, dropped when warm
		phys.cold <= 1'b1;
		repeat (5) @(posedge clk);
		wr(SMM_CMD_OFS, p & 32'hFFDFFFFF);
		repeat (6) @(posedge clk);
		`CHK(bst, 1'b1)
		phys <= 5'b00011;
		repeat (8) @(posedge clk);
		`CHK(bst, 1'b0)
		rd(SMM_PARAM_OFS, 32'h00200000, 32'h00200000, 1'b0);
		phys <= '0;
		// Moves with each stabilization length
		for (int i = 0; i < 4; i++) begin
			wr(SMM_CTRL_OFS, 32'(i) << 22);
			wr(SMM_CMD_OFS, 32'h0025733A | (32'(i) << 22));
			tag = act ^ 11'($urandom_range(1, 2047));
			wr(SMM_CMD_OFS, {5'h0, tag, 12'h0, SMM_CMD_SETPOS});
			`WAITF(run)
			`CHK(tgt, tag)
			`CHK(run, 1'b1)
			`CHK(lvl, 4'h7)
			act <= tag;
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
			`WAITF(frz)
			`CHK(frz, 1'b1)
			for (n = 0; frz && n < 400; n++) @(posedge clk);
			`CHK(run, 1'b0)
			`CHK(lvl, 4'h5)
			len[i] = n;
			if (i > 0)
				`CHK(len[i] - len[i-1], STB << (i - 1))
		end
		// Two-phase move: own set, shape forced in second phase
		tag = act ^ 11'($urandom_range(1, 2047));
		t2 = tag ^ 11'($urandom_range(1, 2047));
		wr(SMM_CMD_OFS, {1'b0, t2, 1'b0, tag, 4'h5, SMM_CMD_TWOPH});
		`WAITF(run)
		`CHK(mot, {4'h5, 4'h3, 4'h3, 1'b0})
		act <= tag;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		@(posedge clk);
		`CHK(mot.shape, 1'b1)
		`CHK(tgt, t2)
		act <= t2;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(mot.shape, 1'b0)
		// Coil fault: shutdown until a status read clears it
		phys <= 5'b00100;
		`WAITF(hoff)
		`CHK(hoff, 1'b1)
		phys <= '0;
		repeat (4) @(posedge clk);
		wr(SMM_CMD_OFS, {28'h0, SMM_CMD_FSTATUS});
		rd(SMM_RDPAR_OFS, 32'hFFFFFFFF, 32'h0000033A, 1'b0);
		`CHK(hoff, 1'b0)
		wr(SMM_CMD_OFS, {28'h0, SMM_CMD_DYNID});
		`WAITF(dyn)
		`CHK(dyn, 1'b1)
		// Sleep forbidden, then allowed, then woken
		wr(SMM_CTRL_OFS, 32'h0);
		wr(SMM_CMD_OFS, {28'h0, SMM_CMD_SLEEP});
		repeat (30) @(posedge clk);
		`CHK(slp, 1'b0)
		wr(SMM_CTRL_OFS, 32'h01000000);
		wr(SMM_CMD_OFS, {28'h0, SMM_CMD_SLEEP});
		`WAITF(slp)
		`CHK(slp, 1'b1)
		wr(SMM_CMD_OFS, {28'h0, SMM_CMD_STATUS});
		repeat (8) @(posedge clk);
		`CHK(slp, 1'b0)
		rd(SMM_PARAM_OFS, 32'hFFFFFFFF, SMM_PARAM_RST, 1'b0);
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule
